// ### bench/ddr_burst_sram_port_protocol_tb_top.sv
// Purpose: Controller and SRAM ends joined, driven through the command port
// Assumes: 18-bit words, 64-word memory, 20 MHz mclk
// Notes: Expected data kept in a lane-masked shadow memory
`timescale 1ns/1ns
module ddr_burst_sram_port_protocol_tb_top;
    logic mclk_in;
    logic rst_in;
    logic clk_run_in;
    logic full_latency_in;
    logic cmd_valid_in;
    logic cmd_ready_out;
    logic cmd_write_in;
    logic [5:0] cmd_addr_in;
    logic [35:0] cmd_wdata_in;
    logic [3:0] cmd_sel_n_in;
    logic [35:0] rdata_out;
    logic rdata_valid_out;
    logic [17:0] mem [64];
    logic [35:0] exp_q [$];
    int num_errors;
    int tests_run;
    int n;
    bit took;

    ddr_sram_link_if #(.DATA_W(18), .ADDR_W(6)) link ();
    ddr_sram_ctrl u_ddr_sram_ctrl (
        .mclk_in(mclk_in), .rst_in(rst_in), .clk_run_in(clk_run_in),
        .full_latency_in(full_latency_in), .cmd_valid_in(cmd_valid_in),
        .cmd_ready_out(cmd_ready_out), .cmd_write_in(cmd_write_in),
        .cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
        .cmd_sel_n_in(cmd_sel_n_in), .rdata_out(rdata_out),
        .rdata_valid_out(rdata_valid_out), .link(link.ctrl_mp));
    ddr_sram_device u_ddr_sram_device (
        .mclk_in(mclk_in), .rst_in(rst_in), .link(link.dev_mp));
    ddr_sram_link_props u_ddr_sram_link_props (
        .mclk_in(mclk_in), .rst_in(rst_in), .k(link.k), .k_n(link.k_n),
        .read_port_select_n(link.read_port_select_n),
        .write_port_select_n(link.write_port_select_n), .addr(link.addr), .d(link.d),
        .byte_lane_write_select_n(link.byte_lane_write_select_n),
        .pll_disable_n(link.pll_disable_n), .q(link.q), .q_oe(link.q_oe),
        .read_valid_flag(link.read_valid_flag), .echo_clock(link.echo_clock));

    initial mclk_in = 1'b0;
    always #25 mclk_in = ~mclk_in;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_word(input string name, input logic [35:0] exp, input logic [35:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [35:0] exp_of(input logic [5:0] a);
        return {mem[a + 6'h1], mem[a]};
    endfunction
    // One offer; ready sampled at negedge since it is registered
    task automatic offer(input logic w, input logic [5:0] a, input logic [35:0] data,
            input logic [3:0] sel, output bit ok);
        logic r;
        cmd_valid_in <= 1'b1;
        {cmd_write_in, cmd_addr_in, cmd_wdata_in, cmd_sel_n_in} <= {w, a, data, sel};
        @(negedge mclk_in);
        r = cmd_ready_out;
        @(posedge mclk_in);
        ok = (r === 1'b1);
    endtask
    task automatic send(input logic w, input logic [5:0] a, input logic [35:0] data,
            input logic [3:0] sel);
        bit ok;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            offer(w, a, data, sel, ok);
        end
        if (!ok) begin
            num_errors++;
            results();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [35:0] data, input logic [3:0] sel);
        send(1'b1, a, data, sel);
        for (int i = 0; i < 4; i++) begin
            if (!sel[i]) begin
                mem[a + 6'(i / 2)][(i % 2) * 9 +: 9] = data[i * 9 +: 9];
            end
        end
    endtask
    task automatic rd(input logic [5:0] a);
        send(1'b0, a, 36'h0_0000_0000, 4'hF);
        exp_q.push_back(exp_of(a));
    endtask
    task automatic drain(input int cnt);
        bit seen;
        for (int j = 0; j < cnt; j++) begin
            seen = 1'b0;
            for (int i = 0; i < 400 && !seen; i++) begin
                @(negedge mclk_in);
                seen = (rdata_valid_out === 1'b1);
            end
            if (!seen) begin
                num_errors++;
                results();
            end
            cmp_word("rdata_out", exp_q.pop_front(), rdata_out);
        end
        @(posedge mclk_in);
    endtask
    task automatic rd_chk(input logic [5:0] a);
        rd(a);
        cmd_valid_in <= 1'b0;
        drain(1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_in = 1'b1;
        clk_run_in = 1'b1;
        full_latency_in = 1'b1;
        cmd_valid_in = 1'b0;
        {cmd_write_in, cmd_addr_in, cmd_wdata_in, cmd_sel_n_in} = {1'b0, 6'h00, 36'h0_0000_0000, 4'hF};
        num_errors = 0;
        tests_run = 0;
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        @(negedge mclk_in);
        cmp_bit("q_oe", 1'b0, link.q_oe);
        cmp_bit("read_valid_flag", 1'b0, link.read_valid_flag);
        @(posedge mclk_in);
        wr(6'h05, 36'h9_8765_4321, 4'h0);
        rd_chk(6'h05);
        wr(6'h3F, 36'h5_A5A5_A5A5, 4'h0);
        rd_chk(6'h3F);
        wr(6'h0A, 36'h0_0000_0000, 4'h0);
        // Every select pattern per word, both words differing
        for (int i = 0; i < 16; i++) begin
            wr(6'h0A, 36'h1_2345_6789 ^ {9{4'(i)}}, 4'(i));
            rd_chk(6'h0A);
        end
        wr(6'h14, 36'h3_C3C3_C3C3, 4'h0);
        rd(6'h14);
        cmd_valid_in <= 1'b0;
        drain(1);
        full_latency_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        rd_chk(6'h05);
        full_latency_in <= 1'b1;
        // Parked clock lets the queue fill until refused
        clk_run_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        n = 0;
        took = 1'b1;
        for (int i = 0; i < 40 && took; i++) begin
            offer(1'b0, 6'h3F, 36'h0_0000_0000, 4'hF, took);
            if (took) begin
                exp_q.push_back(exp_of(6'h3F));
                n++;
            end
        end
        cmd_valid_in <= 1'b0;
        cmp_word("queued_reads", 36'h0_0000_0020, 36'(n));
        clk_run_in <= 1'b1;
        drain(n);
        repeat (20) @(posedge mclk_in);
        @(negedge mclk_in);
        cmp_bit("q_oe", 1'b0, link.q_oe);
        cmp_bit("read_valid_flag", 1'b0, link.read_valid_flag);
        results();
    end
endmodule

// ### bench/ddr_sram_link_props.sv
// Purpose: Protocol checks on the pins between controller and burst SRAM
// Assumes: One mclk domain; link clock rises seen as level changes
// Notes: Latency figures follow the hand-over walk
`timescale 1ns/1ns
module ddr_sram_link_props #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 6
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic k,
    input wire logic k_n,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] d,
    input wire logic [DATA_W/9-1:0] byte_lane_write_select_n,
    input wire logic pll_disable_n,
    input wire logic [DATA_W-1:0] q,
    input wire logic q_oe,
    input wire logic read_valid_flag,
    input wire logic echo_clock
);
    ////////////////////////////////////////////////////////////////////////////////
    // K rises since the last read start; saturates so long idles stay idle
    logic k_prev;
    logic [2:0] idle_k;
    logic [2:0] next_idle_k;
    always_comb begin
        next_idle_k = idle_k;
        if (k && !k_prev && !read_port_select_n) begin
            next_idle_k = 3'h0;
        end else if (k && !k_prev && idle_k != 3'h7) begin
            next_idle_k = idle_k + 3'h1;
        end
    end
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            k_prev <= 1'b1;
            idle_k <= 3'h7;
        end else begin
            k_prev <= k;
            idle_k <= next_idle_k;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence s_rd_full;
        k && !$past(k) && !read_port_select_n && pll_disable_n;
    endsequence
    sequence s_rd_legacy;
        k && !$past(k) && !read_port_select_n && !pll_disable_n;
    endsequence
    sequence s_parked;
        (k && k_n)[*3];
    endsequence
    property p_reset_idle;
        $past(rst_in) |-> !q_oe && !read_valid_flag && read_port_select_n && write_port_select_n;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("link busy after reset");
    property p_read_lat2;
        s_rd_full |-> ##4 read_valid_flag ##1 (read_valid_flag && q_oe) ##1 q_oe;
    endproperty
    a_read_lat2: assert property (p_read_lat2) else $error("read data late or early");
    property p_read_lat1;
        s_rd_legacy |-> ##3 q_oe[*2];
    endproperty
    a_read_lat1: assert property (p_read_lat1) else $error("legacy read latency wrong");
    property p_launch_edges;
        q_oe && $past(q_oe) && !$stable(q) |->
            ($past(k) && !$past(k, 2)) || ($past(k_n) && !$past(k_n, 2));
    endproperty
    a_launch_edges: assert property (p_launch_edges) else $error("q moved off a rise");
    property p_float_after_k;
        $fell(q_oe) |-> $past(k) && !$past(k, 2);
    endproperty
    a_float_after_k: assert property (p_float_after_k) else $error("q_oe fell off K");
    property p_nop_quiet;
        idle_k >= 3'h4 |-> !q_oe && !read_valid_flag;
    endproperty
    a_nop_quiet: assert property (p_nop_quiet) else $error("read port active when idle");
    property p_valid_leads;
        $rose(q_oe) |-> $past(read_valid_flag);
    endproperty
    a_valid_leads: assert property (p_valid_leads) else $error("valid flag did not lead");
    property p_write_halves;
        k && !$past(k) && !write_port_select_n |=> k_n && !$past(k_n);
    endproperty
    a_write_halves: assert property (p_write_halves) else $error("write lacks second half");
    property p_standby;
        s_parked |-> $stable(q) && $stable(q_oe);
    endproperty
    a_standby: assert property (p_standby) else $error("outputs moved while parked");
    property p_echo_follows;
        echo_clock == $past(k);
    endproperty
    a_echo_follows: assert property (p_echo_follows) else $error("echo clock wrong");
endmodule

// ### design/cmd_fifo.sv
// Purpose: Command buffer with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes: in_ready_out is registered so it can leave a top module directly
`timescale 1ns/1ns
module cmd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [PW:0] next_count;
    logic next_in_ready;
    logic push;
    logic pop;

    assign out_valid_out = (count != '0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count + (PW+1)'(push) - (PW+1)'(pop);
        next_in_ready = (next_count != (PW+1)'(DEPTH));
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_out <= 1'b0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready_out <= next_in_ready;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule

// ### design/ddr_sram_ctrl.sv
// Purpose: Memory controller end that issues bursts and collects read data
// Assumes: One command per K cycle; read and write never share a cycle
// Notes: Clock stop waits for no burst; the K rise into park gets no K# rise, so a read in flight is not collected intact
`timescale 1ns/1ns
`include "ddr_sram_regs.svh"
module ddr_sram_ctrl
    import ddr_sram_pkg::*;
#(
    parameter int DATA_W = `DATA_W_DEFAULT,
    parameter int ADDR_W = `ADDR_W_DEFAULT,
    parameter int FIFO_DEPTH = `CMD_FIFO_DEPTH
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic clk_run_in,
    input wire logic full_latency_in,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_write_in,
    input wire logic [ADDR_W-1:0] cmd_addr_in,
    input wire logic [2*DATA_W-1:0] cmd_wdata_in,
    input wire logic [2*(DATA_W/`LANE_W)-1:0] cmd_sel_n_in,
    output logic [2*DATA_W-1:0] rdata_out,
    output logic rdata_valid_out,
    ddr_sram_link_if.ctrl_mp link
);
    localparam int LANES = DATA_W / `LANE_W;
    localparam int CW = 1 + ADDR_W + 2 * DATA_W + 2 * LANES;

    link_phase_t phase;
    link_phase_t next_phase;
    logic f_valid;
    logic f_pop;
    logic [CW-1:0] f_data;
    logic cur_write;
    logic [ADDR_W-1:0] cur_addr;
    logic [DATA_W-1:0] cur_d1;
    logic [LANES-1:0] cur_sel1_n;
    logic valid_d;
    logic word_sel;
    logic [DATA_W-1:0] word0;
    logic next_cur_write;
    logic [ADDR_W-1:0] next_cur_addr;
    logic [DATA_W-1:0] next_cur_d1;
    logic [LANES-1:0] next_cur_sel1_n;
    logic next_k;
    logic next_k_n;
    logic next_rps_n;
    logic next_wps_n;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_d;
    logic [LANES-1:0] next_sel_n;

    cmd_fifo #(
        .WIDTH(CW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(cmd_valid_in),
        .in_ready_out(cmd_ready_out),
        .in_data_in({cmd_write_in, cmd_addr_in, cmd_wdata_in, cmd_sel_n_in}),
        .out_valid_out(f_valid),
        .out_ready_in(f_pop),
        .out_data_out(f_data)
    );

    // Only the K phase issues, so the FIFO stalls while clocks are parked
    assign f_pop = f_valid && (next_phase == PH_K);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_phase = phase;
        unique case (phase)
            PH_PARK: if (clk_run_in) next_phase = PH_KN;
            PH_K: next_phase = PH_KN;
            PH_KN: next_phase = clk_run_in ? PH_K : PH_PARK;
        endcase
        next_k = (next_phase != PH_KN);
        next_k_n = (next_phase != PH_K);
        next_rps_n = 1'b1;
        next_wps_n = 1'b1;
        next_addr = link.addr;
        next_d = link.d;
        next_sel_n = link.byte_lane_write_select_n;
        next_cur_write = cur_write;
        next_cur_addr = cur_addr;
        next_cur_d1 = cur_d1;
        next_cur_sel1_n = cur_sel1_n;
        if (f_pop) begin
            // Layout: write, address, word1, word0, selects1, selects0
            next_cur_write = f_data[CW-1];
            next_cur_addr = f_data[CW-2 -: ADDR_W];
            next_cur_d1 = f_data[2*LANES+DATA_W +: DATA_W];
            next_cur_sel1_n = f_data[LANES +: LANES];
            next_rps_n = f_data[CW-1];
            next_wps_n = !f_data[CW-1];
            if (!f_data[CW-1]) begin
                next_addr = f_data[CW-2 -: ADDR_W];
            end
            next_d = f_data[2*LANES +: DATA_W];
            next_sel_n = f_data[0 +: LANES];
        end else if (next_phase == PH_K) begin
            next_cur_write = 1'b0;
        end else if (phase == PH_K && cur_write) begin
            next_addr = cur_addr;
            next_d = cur_d1;
            next_sel_n = cur_sel1_n;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            phase <= PH_PARK;
            link.k <= 1'b1;
            link.k_n <= 1'b1;
            link.read_port_select_n <= 1'b1;
            link.write_port_select_n <= 1'b1;
            link.addr <= '0;
            link.d <= '0;
            link.byte_lane_write_select_n <= '1;
            link.pll_disable_n <= 1'b1;
            cur_write <= 1'b0;
            cur_addr <= '0;
            cur_d1 <= '0;
            cur_sel1_n <= '1;
        end else begin
            phase <= next_phase;
            link.k <= next_k;
            link.k_n <= next_k_n;
            link.read_port_select_n <= next_rps_n;
            link.write_port_select_n <= next_wps_n;
            link.addr <= next_addr;
            link.d <= next_d;
            link.byte_lane_write_select_n <= next_sel_n;
            link.pll_disable_n <= full_latency_in;
            cur_write <= next_cur_write;
            cur_addr <= next_cur_addr;
            cur_d1 <= next_cur_d1;
            cur_sel1_n <= next_cur_sel1_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data follows the valid flag by one cycle, so capture on its delayed copy
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_d <= 1'b0;
            word_sel <= 1'b0;
            word0 <= '0;
            rdata_out <= '0;
            rdata_valid_out <= 1'b0;
        end else begin
            valid_d <= link.read_valid_flag;
            rdata_valid_out <= valid_d && word_sel;
            if (valid_d) begin
                word_sel <= !word_sel;
                if (word_sel) begin
                    rdata_out <= {link.q, word0};
                end else begin
                    word0 <= link.q;
                end
            end
        end
    end
endmodule

// ### design/ddr_sram_device.sv
// Purpose: Cycle model of a separate-port SRAM with two-word DDR bursts
// Assumes: K and K# arrive as levels synchronous to mclk_in; a rise is seen once
// Notes: Memory is read at launch time, so writes that commit earlier are forwarded
//        Undriven q shows the inverse of its last word, so late captures fail
`timescale 1ns/1ns
`include "ddr_sram_regs.svh"

module ddr_sram_device
    import ddr_sram_pkg::*;
#(
    parameter int DATA_W = `DATA_W_DEFAULT,
    parameter int ADDR_W = `ADDR_W_DEFAULT
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    ddr_sram_link_if.dev_mp link
);
    localparam int LANES = DATA_W / `LANE_W;

    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic k_prev;
    logic kn_prev;
    logic k_rise;
    logic kn_rise;

    logic wr_pend;
    logic [DATA_W-1:0] wr_word0;
    logic [LANES-1:0] wr_sel0_n;

    logic [1:0] rd_stage;
    logic [ADDR_W-1:0] rd_addr0;
    logic [ADDR_W-1:0] rd_addr1;
    logic [ADDR_W-1:0] out_addr;

    logic launch;
    logic [ADDR_W-1:0] launch_addr;
    logic commit;
    logic [ADDR_W-1:0] wr_addr_a;
    logic [ADDR_W-1:0] wr_addr_b;
    logic [DATA_W-1:0] merged_a;
    logic [DATA_W-1:0] merged_b;

    // Next values of the write and read groups
    logic next_wr_pend;
    logic [DATA_W-1:0] next_wr_word0;
    logic [LANES-1:0] next_wr_sel0_n;
    logic [1:0] next_rd_stage;
    logic [ADDR_W-1:0] next_rd_addr0;
    logic [ADDR_W-1:0] next_rd_addr1;
    logic [ADDR_W-1:0] next_out_addr;
    logic [DATA_W-1:0] next_q;
    logic next_q_oe;
    logic next_valid;

    // Lanes with a low select take new data, the rest keep old contents
    function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                     input logic [DATA_W-1:0] new_w,
                                                     input logic [LANES-1:0] sel_n);
        logic [DATA_W-1:0] res;
        res = old_w;
        for (int i = 0; i < LANES; i++) begin
            if (!sel_n[i]) begin
                res[i*`LANE_W +: `LANE_W] = new_w[i*`LANE_W +: `LANE_W];
            end
        end
        return res;
    endfunction

    // Edges only exist while the controller toggles K; parked clocks freeze all
    assign k_rise = link.k && !k_prev;
    assign kn_rise = link.k_n && !kn_prev;

    // Latency select: the pipe stage that reaches the output at K, rd_stage[1] when full, rd_stage[0] when legacy
    assign launch = link.pll_disable_n ? rd_stage[1] : rd_stage[0];
    assign launch_addr = link.pll_disable_n ? rd_addr1 : rd_addr0;

    // Write address rides the K# half of the shared bus
    assign commit = kn_rise && wr_pend;
    assign wr_addr_a = link.addr;
    assign wr_addr_b = link.addr + 1'b1;
    assign merged_a = lane_merge(mem[wr_addr_a], wr_word0, wr_sel0_n);
    assign merged_b = lane_merge(mem[wr_addr_b], link.d, link.byte_lane_write_select_n);

    ////////////////////////////////////////////////////////////////////////////
    // Write half: word0 and its selects wait here for the K# half of the burst
    always_comb begin
        next_wr_pend = wr_pend;
        next_wr_word0 = wr_word0;
        next_wr_sel0_n = wr_sel0_n;
        if (k_rise) begin
            // Both selects high fall through here as a no-op
            next_wr_pend = !link.write_port_select_n;
            // Data and selects are don't-care on a NOP, so they are not taken
            if (!link.write_port_select_n) begin
                next_wr_word0 = link.d;
                next_wr_sel0_n = link.byte_lane_write_select_n;
            end
        end else if (commit) begin
            next_wr_pend = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend <= 1'b0;
            wr_word0 <= '0;
            wr_sel0_n <= '1;
        end else begin
            wr_pend <= next_wr_pend;
            wr_word0 <= next_wr_word0;
            wr_sel0_n <= next_wr_sel0_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read half: two-deep address pipe; word0 launches at K, word1 at K#
    always_comb begin
        next_rd_stage = rd_stage;
        next_rd_addr0 = rd_addr0;
        next_rd_addr1 = rd_addr1;
        next_out_addr = out_addr;
        next_q = link.q;
        next_q_oe = link.q_oe;
        next_valid = link.read_valid_flag;
        if (k_rise) begin
            next_rd_stage = {rd_stage[0], !link.read_port_select_n};
            next_rd_addr0 = link.addr;
            next_rd_addr1 = rd_addr0;
            // Word1 address comes from the same launch, read again at K#
            next_out_addr = launch_addr;
            next_q_oe = launch;
            next_valid = launch;
            if (launch) begin
                next_q = mem[launch_addr];
            end else if (link.q_oe) begin
                // Released bus shows the inverse rather than the last word
                next_q = ~link.q;
            end
        end else if (kn_rise) begin
            // Flag rises one half cycle ahead of the burst that starts at next K
            next_valid = launch;
            if (link.q_oe) begin
                next_q = mem[out_addr + 1'b1];
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_stage <= 2'h0;
            rd_addr0 <= '0;
            rd_addr1 <= '0;
            out_addr <= '0;
            link.q <= '0;
            link.q_oe <= 1'b0;
            link.read_valid_flag <= 1'b0;
        end else begin
            rd_stage <= next_rd_stage;
            rd_addr0 <= next_rd_addr0;
            rd_addr1 <= next_rd_addr1;
            out_addr <= next_out_addr;
            link.q <= next_q;
            link.q_oe <= next_q_oe;
            link.read_valid_flag <= next_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Last link clock levels reset to the parked level, so release shows no rise
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            k_prev <= 1'b1;
            kn_prev <= 1'b1;
            link.echo_clock <= 1'b1;
        end else begin
            k_prev <= link.k;
            kn_prev <= link.k_n;
            link.echo_clock <= link.k;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array has no reset; both words of a burst commit together at K#
    always_ff @(posedge mclk_in) begin
        if (commit) begin
            mem[wr_addr_a] <= merged_a;
            if (wr_addr_b != wr_addr_a) begin
                mem[wr_addr_b] <= merged_b;
            end
        end
    end
endmodule

// ### design/ddr_sram_link_if.sv
// Purpose: Pin bundle between memory controller and burst SRAM
// Assumes: Widths match on both ends
// Notes: Read data carries an output enable instead of a floating bus
`timescale 1ns/1ns
interface ddr_sram_link_if #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 6
);
    localparam int LANES = DATA_W / 9;
    logic k;
    logic k_n;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d;
    logic [LANES-1:0] byte_lane_write_select_n;
    logic pll_disable_n;
    logic [DATA_W-1:0] q;
    logic q_oe;
    logic read_valid_flag;
    logic echo_clock;

    modport ctrl_mp (
        output k, k_n, read_port_select_n, write_port_select_n, addr, d,
        output byte_lane_write_select_n, pll_disable_n,
        input q, q_oe, read_valid_flag, echo_clock
    );
    modport dev_mp (
        input k, k_n, read_port_select_n, write_port_select_n, addr, d,
        input byte_lane_write_select_n, pll_disable_n,
        output q, q_oe, read_valid_flag, echo_clock
    );
endinterface

// ### design/ddr_sram_pkg.sv
// Purpose: Types shared by both ends of the burst SRAM link
// Assumes: Nothing beyond the constants header
// Notes: Link clock phases are one-hot
package ddr_sram_pkg;
    typedef enum logic [2:0] {
        PH_PARK = 3'b001,
        PH_K = 3'b010,
        PH_KN = 3'b100
    } link_phase_t;
endpackage

// ### design/ddr_sram_regs.svh
// Purpose: Shared constants of the two-word burst SRAM port and its controller
// Assumes: One system clock; K and K# are phase levels made by the controller
// Notes: Definitions only
`ifndef DDR_SRAM_REGS_SVH
`define DDR_SRAM_REGS_SVH

`define DATA_W_DEFAULT 18
`define ADDR_W_DEFAULT 6
`define LANE_W 9
`define RD_LAT_FULL 2
`define RD_LAT_LEGACY 1
`define CMD_FIFO_DEPTH 32

`endif
